// >>> bench/csl_loader_props.sv
`timescale 1ns/1ps
module csl_loader_props
  import csl_pkg::*;
#(
  parameter int unsigned NPAR = 16
) (
  // watched ports
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic [CSL_AW-1:0] reg_addr_i,
  input wire logic [CSL_DW-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [CSL_DW-1:0] reg_rdata_o,
  input wire logic              acq_active_i,
  input wire logic [1:0]        nv_set_o,
  input wire logic [$clog2(NPAR)-1:0] nv_idx_o,
  input wire logic              live_valid_o
);
  // copy-length window; HB adds slack for the two-flop acquisition synchroniser
  localparam int LO = NPAR - 1;
  localparam int HI = NPAR + 2;
  localparam int HB = NPAR + 6;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_boot_idle;
    $fell(sys_rst_i) && !acq_active_i ##1 !acq_active_i;
  endsequence
  sequence s_acq_held;
    acq_active_i [*4];
  endsequence
  sequence s_go;
    (!acq_active_i) [*3] ##0 (reg_wr_i && reg_addr_i == CSL_OFF_FETCH
      && reg_wdata_i == CSL_FETCH_GO && live_valid_o);
  endsequence
  a_fetch_start: assert property (s_go |-> ##[1:2] !live_valid_o)
    else $error("fetch did not start a copy");
  a_copy_len: assert property ($fell(live_valid_o) |-> ##[LO:HI] live_valid_o)
    else $error("copy length wrong");
  a_idx_step: assert property ($changed(nv_idx_o) && nv_idx_o != '0
    |-> nv_idx_o == $past(nv_idx_o) + 1'b1) else $error("index skipped");
  a_set_hold: assert property ($changed(nv_set_o) |-> nv_idx_o == '0)
    else $error("set changed mid copy");
  a_acq_block: assert property (s_acq_held |-> !$fell(live_valid_o))
    else $error("copy during acquisition");
  a_fetch_reads0: assert property (reg_rd_i && reg_addr_i == CSL_OFF_FETCH
    |=> reg_rdata_o == '0) else $error("fetch reads nonzero");
  a_rst_volatile: assert property ($fell(sys_rst_i) |-> !live_valid_o)
    else $error("live valid kept over reset");
  a_boot_copy: assert property (s_boot_idle |-> ##[LO:HB] live_valid_o)
    else $error("no startup copy");
endmodule // csl_loader_props

bind csl_loader csl_loader_props #(.NPAR(NPAR)) u_props (.*);

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  import csl_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, acq_active_i = 0;
  logic [3:0]  reg_addr_i = '0, live_idx_i = '0, nv_idx_o;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o, rdv;
  logic [15:0] nv_data_i = '0, live_data_o;
  logic [1:0]  nv_set_o;
  logic        live_valid_o;
  int          errors = 0, checks_done = 0;
  always #20 clk_i = ~clk_i;
  // stored sets: pattern names set and index, one-cycle latency
  always @(posedge clk_i) nv_data_i <= {6'h00, nv_set_o, 4'h5, nv_idx_o};
  csl_loader #(.NPAR(16), .PW(16)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acq_active_i(acq_active_i),
    .nv_set_o(nv_set_o), .nv_idx_o(nv_idx_o), .nv_data_i(nv_data_i),
    .live_idx_i(live_idx_i), .live_data_o(live_data_o), .live_valid_o(live_valid_o));
  task results;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 rdv = reg_rdata_o;
  endtask
  // bounded: a stuck copy ends the run
  task wait_valid;
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    #1;
    while (live_valid_o !== 1'b1 && n < 200) begin
      @(posedge clk_i) #1;
      n++;
    end
    if (n == 200) begin
      errors++;
      results();
    end
  endtask
  task live_is(input logic [1:0] s);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i) live_idx_i <= i[3:0];
      @(posedge clk_i) #1 chk({16'h0000, live_data_o}, {22'h00_0000, s, 4'h5, i[3:0]});
    end
  endtask
  task t_regs;
    rd(CSL_OFF_CHOICE);
    chk(rdv, 32'h0000_0000);
    rd(CSL_OFF_BOOT);
    chk(rdv, 32'h0000_0003);
    rd(CSL_OFF_FETCH);
    chk(rdv, 32'h0000_0000);
    rd(4'h2);
    chk(rdv, 32'h0000_0000);
    wr(CSL_OFF_BOOT, 32'h0000_0002);
    rd(CSL_OFF_BOOT);
    chk(rdv, 32'h0000_0002);
  endtask
  task t_load;
    for (int s = 0; s < 4; s++) begin
      wr(CSL_OFF_CHOICE, s);
      wr(CSL_OFF_FETCH, CSL_FETCH_GO);
      rd(CSL_OFF_STATUS);
      chk(rdv, {26'h000_0000, s[1:0], 4'h1});
      wait_valid();
      live_is(s[1:0]);
    end
    rd(CSL_OFF_STATUS);
    chk(rdv, 32'h0000_0032);
  endtask
  task t_acq;
    @(posedge clk_i) acq_active_i <= 1;
    repeat (4) @(posedge clk_i);
    wr(CSL_OFF_CHOICE, 32'h0000_0001);
    wr(CSL_OFF_FETCH, CSL_FETCH_GO);
    repeat (20) @(posedge clk_i);
    rd(CSL_OFF_STATUS);
    chk(rdv & 32'h0000_0004, 32'h0000_0004);
    live_is(2'h3);
    @(posedge clk_i) acq_active_i <= 0;
    repeat (4) @(posedge clk_i);
    wr(CSL_OFF_FETCH, 32'h0000_0002);
    repeat (4) @(posedge clk_i);
    live_is(2'h3);
  endtask
  task t_boot;
    @(posedge clk_i) sys_rst_i <= 1;
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0000_0000, live_valid_o}, 32'h0000_0000);
    @(posedge clk_i) sys_rst_i <= 0;
    wait_valid();
    live_is(CSL_BOOT_RST);
    // busy pin holds the startup copy off while the boot choice is written
    @(posedge clk_i);
    sys_rst_i <= 1;
    acq_active_i <= 1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 0;
    wr(CSL_OFF_BOOT, 32'h0000_0001);
    repeat (8) @(posedge clk_i);
    #1 chk({31'h0000_0000, live_valid_o}, 32'h0000_0000);
    @(posedge clk_i) acq_active_i <= 0;
    wait_valid();
    live_is(2'h1);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 0;
    wait_valid();
    live_is(CSL_BOOT_RST);
    t_regs();
    t_load();
    t_acq();
    t_boot();
    results();
  end
endmodule // tb

// >>> rtl/csl_loader.sv
`timescale 1ns/1ps
module csl_loader #(
  parameter int unsigned NPAR = 16,
  parameter int unsigned PW   = 16
) (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  // register port
  input  wire logic [csl_pkg::CSL_AW-1:0]     reg_addr_i,
  input  wire logic [csl_pkg::CSL_DW-1:0]     reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [csl_pkg::CSL_DW-1:0]     reg_rdata_o,
  // acquisition status pin
  input  wire logic                           acq_active_i,
  // stored set memory, one-cycle read latency
  output logic      [csl_pkg::CSL_SET_W-1:0]  nv_set_o,
  output logic      [$clog2(NPAR)-1:0]        nv_idx_o,
  input  wire logic [PW-1:0]                  nv_data_i,
  // live parameter read port
  input  wire logic [$clog2(NPAR)-1:0]        live_idx_i,
  output logic      [PW-1:0]                  live_data_o,
  output logic                                live_valid_o
);
  import csl_pkg::*;
  localparam int unsigned IW = $clog2(NPAR);
  localparam logic [IW-1:0] LAST_IDX = IW'(NPAR - 1);

  logic                 acq_s;
  logic [PW-1:0]        live_mem [NPAR];
  csl_state_type        state_r, state_nxt;
  logic [CSL_SET_W-1:0] choice_r, choice_nxt;
  logic [CSL_SET_W-1:0] boot_r, boot_nxt;
  logic [CSL_SET_W-1:0] cur_r, cur_nxt;
  logic [IW-1:0]        idx_r, idx_nxt;
  logic                 rd_pend_r, rd_pend_nxt;
  logic [IW-1:0]        wr_idx_r, wr_idx_nxt;
  logic                 boot_pend_r, boot_pend_nxt;
  logic                 valid_r, valid_nxt;
  logic                 done_r, done_nxt;
  logic                 rej_r, rej_nxt;
  logic [CSL_DW-1:0]    rdata_nxt;
  logic                 fetch_req;
  logic                 start_boot;
  logic                 start_user;
  logic                 copy_end;
  logic [PW-1:0]        live_data_nxt;

  csl_sync u_acq_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (acq_active_i),
    .q_o       (acq_s)
  );

  assign fetch_req = reg_wr_i && (reg_addr_i == CSL_OFF_FETCH)
    && (reg_wdata_i == CSL_FETCH_GO);

  // startup copy first; either start needs an idle engine and a quiet pin
  assign start_boot = (state_r == CSL_IDLE) && boot_pend_r && !acq_s;
  assign start_user = (state_r == CSL_IDLE) && !boot_pend_r && fetch_req && !acq_s;
  assign copy_end   = rd_pend_r && (wr_idx_r == LAST_IDX);

  // selector registers
  // boot choice is volatile here; keeping it over power loss is outside
  always_comb begin
    choice_nxt = choice_r;
    boot_nxt   = boot_r;
    // 2-bit field covers all four sets, so any write is legal
    if (reg_wr_i && reg_addr_i == CSL_OFF_CHOICE) begin
      choice_nxt = reg_wdata_i[CSL_SET_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == CSL_OFF_BOOT) begin
      boot_nxt = reg_wdata_i[CSL_SET_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      choice_r <= CSL_CHOICE_RST;
      boot_r   <= CSL_BOOT_RST;
    end else begin
      choice_r <= choice_nxt;
      boot_r   <= boot_nxt;
    end
  end

  // copy engine, one index per cycle
  always_comb begin
    state_nxt     = state_r;
    cur_nxt       = cur_r;
    idx_nxt       = idx_r;
    rd_pend_nxt   = 1'b0;
    wr_idx_nxt    = idx_r;
    boot_pend_nxt = boot_pend_r;
    case (state_r)
      CSL_IDLE: begin
        // startup load waits for a quiet pin too
        if (start_boot) begin
          cur_nxt       = boot_r;
          boot_pend_nxt = 1'b0;
          idx_nxt       = '0;
          state_nxt     = CSL_COPY;
        end else if (start_user) begin
          cur_nxt   = choice_r;
          idx_nxt   = '0;
          state_nxt = CSL_COPY;
        end
      end
      CSL_COPY: begin
        rd_pend_nxt = 1'b1;
        if (idx_r == LAST_IDX) begin
          state_nxt = CSL_IDLE;
        end else begin
          idx_nxt = idx_r + 1'b1;
        end
      end
      default: state_nxt = CSL_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r     <= CSL_IDLE;
      cur_r       <= CSL_SET_DFLT;
      idx_r       <= '0;
      rd_pend_r   <= 1'b0;
      wr_idx_r    <= '0;
      boot_pend_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      cur_r       <= cur_nxt;
      idx_r       <= idx_nxt;
      rd_pend_r   <= rd_pend_nxt;
      wr_idx_r    <= wr_idx_nxt;
      boot_pend_r <= boot_pend_nxt;
    end
  end

  // status flags
  always_comb begin
    valid_nxt = valid_r;
    done_nxt  = done_r;
    rej_nxt   = rej_r;
    if (copy_end) begin
      done_nxt  = 1'b1;
      valid_nxt = 1'b1;
    end
    // a start in the closing cycle wins: the storage is about to change
    if (start_boot || start_user) begin
      done_nxt  = 1'b0;
      valid_nxt = 1'b0;
    end
    // refused while the pin is busy or a copy runs; a startup start drops it silently
    if (start_user) begin
      rej_nxt = 1'b0;
    end else if (fetch_req && !start_boot) begin
      rej_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid_r <= 1'b0;
      done_r  <= 1'b0;
      rej_r   <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      done_r  <= done_nxt;
      rej_r   <= rej_nxt;
    end
  end

  // read data, zero outside the cycle after a read strobe
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        CSL_OFF_CHOICE: rdata_nxt[CSL_SET_W-1:0] = choice_r;
        CSL_OFF_BOOT:   rdata_nxt[CSL_SET_W-1:0] = boot_r;
        CSL_OFF_STATUS: begin
          rdata_nxt[CSL_ST_BUSY] = (state_r == CSL_COPY) || rd_pend_r;
          rdata_nxt[CSL_ST_DONE] = done_r;
          rdata_nxt[CSL_ST_REJ]  = rej_r;
          rdata_nxt[CSL_ST_SET +: CSL_SET_W] = cur_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // memory array has no reset; valid flag marks it stale
  always_ff @(posedge clk_i) begin
    if (rd_pend_r) begin
      live_mem[wr_idx_r] <= nv_data_i;
    end
  end

  // live read port
  always_comb begin
    live_data_nxt = live_mem[live_idx_i];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      live_data_o <= '0;
    end else begin
      live_data_o <= live_data_nxt;
    end
  end

  assign nv_set_o     = cur_r;
  assign nv_idx_o     = idx_r;
  assign live_valid_o = valid_r;
endmodule // csl_loader

// >>> rtl/csl_pkg.sv
// Behaviour
// - a load overwrites every live parameter with the chosen stored set
// - besides three user slots, the default set can be loaded
// - loads only while idle; host must not load during acquisition
// - stored set choice offers user slot 1, 2, 3 and default
// - writing 1 to the fetch command starts copying the chosen set
// - at power-on and after reset the boot set is copied automatically
// - boot set choice names slot 1, 2, 3 or default for startup
// - live storage is volatile and not cleared by reset (reset only drops the valid flag), hence the startup load
package csl_pkg;
  localparam int unsigned CSL_AW = 4;
  localparam int unsigned CSL_DW = 32;
  localparam int unsigned CSL_SET_W = 2;
  // register offsets (byte addresses)
  localparam logic [CSL_AW-1:0] CSL_OFF_CHOICE = 4'h0;
  localparam logic [CSL_AW-1:0] CSL_OFF_FETCH  = 4'h4;
  localparam logic [CSL_AW-1:0] CSL_OFF_BOOT   = 4'h8;
  localparam logic [CSL_AW-1:0] CSL_OFF_STATUS = 4'hC;
  // set codes
  localparam logic [CSL_SET_W-1:0] CSL_SET_USER1 = 2'h0;
  localparam logic [CSL_SET_W-1:0] CSL_SET_USER2 = 2'h1;
  localparam logic [CSL_SET_W-1:0] CSL_SET_USER3 = 2'h2;
  localparam logic [CSL_SET_W-1:0] CSL_SET_DFLT  = 2'h3;
  localparam logic [CSL_SET_W-1:0] CSL_CHOICE_RST = CSL_SET_USER1;
  localparam logic [CSL_SET_W-1:0] CSL_BOOT_RST   = CSL_SET_DFLT;
  localparam logic [CSL_DW-1:0]    CSL_FETCH_GO   = 32'h0000_0001;
  // status bit positions
  localparam int unsigned CSL_ST_BUSY = 0;
  localparam int unsigned CSL_ST_DONE = 1;
  localparam int unsigned CSL_ST_REJ  = 2;
  localparam int unsigned CSL_ST_SET  = 4;
  typedef enum logic [1:0] {CSL_IDLE, CSL_COPY} csl_state_type;
endpackage

// >>> rtl/csl_sync.sv
`timescale 1ns/1ps
module csl_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  // resets to busy: a startup copy must not slip in before the pin is really seen
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end
endmodule // csl_sync
